// ---- core/motion_sample_buffer.sv ----
// motion sample buffer with four modes and a wishbone register slave
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module motion_sample_buffer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // sensor datapath
  input wire logic sample_valid,
  input wire logic [47:0] sample_data,
  input wire logic motion_irq,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // status outputs
  output logic wmk_level,
  output logic irq
);
  import motion_buf_pkg::*;

  // ****************
  // state
  // ****************
  mode_t mode_q, mode_d;
  logic res_q, res_d;
  logic [9:0] th_q, th_d;
  logic [NUM_EV-1:0] mask_q, mask_d;
  logic [CNT_W-1:0] head_q, head_d, cnt_q, cnt_d, slot_q, slot_d;
  logic trig_q, trig_d;
  logic pend_q, pend_d;
  logic [47:0] smp_q, smp_d;
  wr_state_t wr_q, wr_d;
  logic [2:0] widx_q, widx_d, ridx_q, ridx_d;
  logic [1:0] stage_q, stage_d;
  logic ack_d;
  logic [31:0] dat_d;
  logic [7:0] rdata;
  logic [ADDR_W-1:0] waddr, raddr;
  logic [7:0] wdata;
  logic [CNT_W-1:0] cap, newest, above;
  logic [2:0] bps;
  logic full, commit, drop, rd_done, data_rd, ctrl_wr, stat_rd;
  logic [NUM_EV-1:0] ev_set, status;

  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] n;
    n = a + 11'h001;
    wrap_inc = (n >= c) ? 11'h000 : n;
  endfunction

  function automatic logic [CNT_W-1:0] wrap_add(input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] b,
                                                input logic [CNT_W-1:0] c);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    wrap_add = (s >= {1'b0, c}) ? CNT_W'(s - {1'b0, c}) : s[CNT_W-1:0];
  endfunction

  // ****************
  // geometry and decode
  // ****************
  assign bps = res_q ? BPS_HI : BPS_LO;
  assign cap = res_q ? CAP_HI : CAP_LO;
  assign full = (cnt_q == cap);
  assign newest = wrap_add(head_q, cnt_q - 11'h001, cap);
  assign above = (cnt_q > {1'b0, th_q}) ? cnt_q - {1'b0, th_q} : 11'h000;
  assign wmk_level = mode_q != MODE_TRIG && cnt_q >= 11'(th_q);
  assign commit = (wr_q == WR_BUSY) && (widx_q == bps - 3'h1);
  assign data_rd = (stage_q == 2'h2) && !we_i && (adr_i == OFS_DATA);
  assign rd_done = data_rd && (cnt_q != 11'h000) && (ridx_q == bps - 3'h1);
  assign ctrl_wr = (stage_q == 2'h2) && we_i && sel_i[0] && adr_i == OFS_CTRL;
  assign stat_rd = (stage_q == 2'h2) && !we_i && (adr_i == OFS_STATUS);

  // full stream or filo, or pre-trigger window reached, overwrites oldest
  always_comb begin
    drop = 1'b0;
    case (mode_q)
      MODE_STREAM, MODE_FILO: drop = full;
      MODE_TRIG: drop = !trig_q && (full ||
                        (th_q != 10'h000 && cnt_q >= 11'(th_q)));
      default: drop = 1'b0;
    endcase
  end

  // ****************
  // memory ports
  // ****************
  // slot times bytes per sample fits the 11-bit byte address
  assign waddr = ADDR_W'(slot_q * bps + 11'(widx_q));
  // low resolution keeps the high byte of each axis
  assign wdata = res_q ? smp_q[widx_q*8 +: 8] : smp_q[widx_q*16 + 8 +: 8];
  always_comb begin
    if (mode_q == MODE_FILO) begin
      raddr = ADDR_W'(newest * bps + 11'(bps - 3'h1 - ridx_q));
    end else begin
      raddr = ADDR_W'(head_q * bps + 11'(ridx_q));
    end
  end

  sample_mem u_mem (
    .ref_clk(ref_clk),
    .we(wr_q == WR_BUSY),
    .waddr(waddr),
    .wdata(wdata),
    .raddr(raddr),
    .rdata(rdata)
  );

  // ****************
  // interrupt status
  // ****************
  assign ev_set[ST_WMK] = wmk_level && (cnt_q == {1'b0, th_q});
  assign ev_set[ST_TRIG] = trig_d && !trig_q;
  assign ev_set[ST_FULL] = full;
  for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
    sticky_bit u_bit (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set(ev_set[i]),
      .clr(stat_rd),
      .q(status[i])
    );
  end
  assign irq = |(status & mask_q);

  // ****************
  // next state
  // ****************
  always_comb begin
    mode_d = mode_q;
    res_d = res_q;
    th_d = th_q;
    mask_d = mask_q;
    head_d = head_q;
    cnt_d = cnt_q;
    slot_d = slot_q;
    trig_d = trig_q;
    pend_d = pend_q;
    smp_d = smp_q;
    wr_d = wr_q;
    widx_d = widx_q;
    ridx_d = ridx_q;
    stage_d = stage_q;
    ack_d = 1'b0;
    dat_d = dat_o;
    // a sample waits here while a bus access is in flight
    if (sample_valid) begin
      pend_d = 1'b1;
      smp_d = sample_data;
    end
    case (wr_q)
      WR_IDLE: begin
        if (pend_q && stage_q == 2'h0 && !ack_o) begin
          pend_d = sample_valid;
          // fifo and post-trigger keep contents once full
          if (!(full && (mode_q == MODE_FIFO ||
                (mode_q == MODE_TRIG && trig_q)))) begin
            wr_d = WR_BUSY;
            widx_d = 3'h0;
            slot_d = wrap_add(head_q, cnt_q, cap);
          end
        end
      end
      WR_BUSY: begin
        widx_d = widx_q + 3'h1;
        if (commit) begin
          wr_d = WR_IDLE;
          if (drop) begin
            head_d = wrap_inc(head_q, cap);
          end else begin
            cnt_d = cnt_q + 11'h001;
          end
        end
      end
      default: wr_d = WR_IDLE;
    endcase
    // trigger only when the pre-event window is complete
    if (mode_q == MODE_TRIG && motion_irq && !trig_q &&
        cnt_q >= {1'b0, th_q}) begin
      trig_d = 1'b1;
    end
    // bus: 0 idle, 1 address to memory, 2 data back and ack
    case (stage_q)
      2'h0: begin
        if (cyc_i && stb_i && !ack_o) begin
          stage_d = 2'h1;
        end
      end
      2'h1: begin
        if (wr_q == WR_IDLE) begin
          stage_d = 2'h2;
        end
      end
      2'h2: begin
        stage_d = 2'h0;
        ack_d = 1'b1;
        dat_d = 32'h0000_0000;
        if (we_i) begin
          case (adr_i)
            OFS_CTRL: begin
              if (sel_i[0]) begin
                mode_d = mode_t'(dat_i[CTRL_MODE_LSB +: 2]);
                res_d = dat_i[CTRL_RES_BIT];
              end
            end
            OFS_THRESH: begin
              if (sel_i[0]) th_d[7:0] = dat_i[7:0];
              if (sel_i[1]) th_d[9:8] = dat_i[9:8];
            end
            OFS_MASK: begin
              if (sel_i[0]) mask_d = dat_i[NUM_EV-1:0];
            end
            default: dat_d = 32'h0000_0000;
          endcase
        end else begin
          case (adr_i)
            OFS_CTRL: dat_d = {29'h0, res_q, mode_q};
            OFS_THRESH: dat_d = {22'h0, th_q};
            OFS_LEVEL: dat_d = {21'h0, cnt_q};
            OFS_DATA: dat_d = (cnt_q != 11'h000) ? {24'h0, rdata} : 32'h0;
            OFS_STATUS: dat_d = {29'h0, status};
            OFS_MASK: dat_d = {29'h0, mask_q};
            OFS_STATE: dat_d = {19'h0, above, trig_q, wmk_level};
            default: dat_d = 32'h0000_0000;
          endcase
        end
        if (data_rd && cnt_q != 11'h000) begin
          ridx_d = (ridx_q == bps - 3'h1) ? 3'h0 : ridx_q + 3'h1;
        end
        if (rd_done) begin
          cnt_d = cnt_q - 11'h001;
          if (mode_q != MODE_FILO) begin
            head_d = wrap_inc(head_q, cap);
          end
        end
      end
      default: stage_d = 2'h0;
    endcase
    // new mode or resolution starts an empty buffer
    if (ctrl_wr) begin
      head_d = 11'h000;
      cnt_d = 11'h000;
      ridx_d = 3'h0;
      trig_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_FIFO;
      res_q <= 1'b0;
      th_q <= THRESH_RST;
      mask_q <= MASK_RST;
      head_q <= 11'h000;
      cnt_q <= 11'h000;
      slot_q <= 11'h000;
      trig_q <= 1'b0;
      pend_q <= 1'b0;
      smp_q <= 48'h0;
      wr_q <= WR_IDLE;
      widx_q <= 3'h0;
      ridx_q <= 3'h0;
      stage_q <= 2'h0;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      mode_q <= mode_d;
      res_q <= res_d;
      th_q <= th_d;
      mask_q <= mask_d;
      head_q <= head_d;
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      trig_q <= trig_d;
      pend_q <= pend_d;
      smp_q <= smp_d;
      wr_q <= wr_d;
      widx_q <= widx_d;
      ridx_q <= ridx_d;
      stage_q <= stage_d;
      ack_o <= ack_d;
      dat_o <= dat_d;
    end
  end

  // ****************
  // checks
  // ****************
  default clocking chk_clk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_count_bound: assert property (cnt_q <= cap)
    else $error("count above capacity");
  a_six_bytes: assert property ($rose(wr_q == WR_BUSY) && res_q |->
    (wr_q == WR_BUSY) [*6] ##1 (wr_q == WR_IDLE))
    else $error("sample not six bytes");
  a_wmk_sticky: assert property ($rose(wmk_level) && !stat_rd |=>
    status[ST_WMK]) else $error("watermark not flagged");
  a_trig_window: assert property (mode_q == MODE_TRIG && !trig_q &&
    th_q != 10'h000 && !ctrl_wr && $stable(th_q) &&
    $past(cnt_q <= {1'b0, th_q}) |-> cnt_q <= {1'b0, th_q})
    else $error("pre-trigger window grew");
  a_fifo_reject: assert property (mode_q == MODE_FIFO && full &&
    wr_q == WR_IDLE && !rd_done && !ctrl_wr |=>
    wr_q == WR_IDLE && cnt_q == $past(cnt_q))
    else $error("full fifo accepted");
  a_stream_drop: assert property (commit && full &&
    (mode_q == MODE_STREAM || mode_q == MODE_FILO) |=>
    cnt_q == $past(cnt_q) && head_q != $past(head_q))
    else $error("full stream did not drop oldest");
  a_fifo_pop: assert property (rd_done && mode_q != MODE_FILO &&
    !ctrl_wr |=> cnt_q == $past(cnt_q) - 11'h001 &&
    head_q == wrap_inc($past(head_q), cap))
    else $error("oldest not removed");
  a_filo_pop: assert property (rd_done && mode_q == MODE_FILO &&
    !ctrl_wr |=> head_q == $past(head_q) &&
    cnt_q == $past(cnt_q) - 11'h001)
    else $error("filo pop moved older data");
  a_trig_flag: assert property (mode_q == MODE_TRIG && motion_irq &&
    cnt_q >= {1'b0, th_q} && !ctrl_wr |=> trig_q)
    else $error("trigger flag not set");
endmodule

// ---- core/motion_buf_pkg.sv ----
// shared constants for the motion sample buffer
package motion_buf_pkg;
  // ****************
  // buffer geometry
  // ****************
  localparam int BUF_BYTES = 2048;
  localparam int ADDR_W = 11;
  localparam int CNT_W = 11;
  localparam logic [2:0] BPS_HI = 3'h6;
  localparam logic [2:0] BPS_LO = 3'h3;
  localparam logic [CNT_W-1:0] CAP_HI = CNT_W'(BUF_BYTES / 6);
  localparam logic [CNT_W-1:0] CAP_LO = CNT_W'(BUF_BYTES / 3);
  // ****************
  // register offsets
  // ****************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_THRESH = 5'h04;
  localparam logic [4:0] OFS_LEVEL = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  localparam logic [4:0] OFS_STATE = 5'h18;
  // ****************
  // fields and reset values
  // ****************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_BIT = 2;
  localparam int ST_WMK = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_FULL = 2;
  localparam int NUM_EV = 3;
  localparam logic [9:0] THRESH_RST = 10'h000;
  localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;
  typedef enum logic [1:0] {
    MODE_FIFO = 2'b00,
    MODE_STREAM = 2'b01,
    MODE_TRIG = 2'b10,
    MODE_FILO = 2'b11
  } mode_t;
  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_BUSY = 1'b1
  } wr_state_t;
endpackage

// ---- core/sample_mem.sv ----
// byte-wide sample storage, one write and one registered read port
`timescale 1ns/10ps
module sample_mem (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic we,
  input wire logic [motion_buf_pkg::ADDR_W-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [motion_buf_pkg::ADDR_W-1:0] raddr,
  output logic [7:0] rdata
);
  import motion_buf_pkg::*;
  logic [7:0] mem_q [BUF_BYTES];
  // no reset: contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule

// ---- core/sticky_bit.sv ----
// one sticky status bit, set wins over clear
`timescale 1ns/10ps
module sticky_bit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic q
);
  logic q_d;
  always_comb begin
    q_d = q;
    if (clr) begin
      q_d = 1'b0;
    end
    if (set) begin
      q_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end
endmodule

// ---- testbench/host_reg_master.sv ----
// wishbone classic master standing in for the host processor
`timescale 1ns/10ps
module host_reg_master (
  // clock
  input wire logic ref_clk,
  // wishbone master side
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [4:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat,
  input wire logic [31:0] rdat,
  input wire logic ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 5'h00;
    sel_o = 4'h0;
    wdat = 32'h0;
  end
  // ****************
  // single classic cycle, waits for ack with no fixed latency
  // ****************
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= wr;
    adr_o <= a;
    sel_o <= 4'hf;
    wdat <= wd;
    @(posedge ref_clk);
    while (ack_i !== 1'b1) @(posedge ref_clk);
    rd = rdat;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines must not keep showing the old request
    we_o <= ~wr;
    adr_o <= ~a;
    wdat <= ~wd;
  endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the motion sample buffer
`timescale 1ns/10ps
module tb;
  import motion_buf_pkg::*;
  typedef struct {mode_t md; logic res; logic [9:0] th; int n;
                  logic [31:0] lvl; logic wmk;} row_t;
  logic ref_clk, rst_n, sample_valid, motion_irq;
  logic [47:0] sample_data;
  logic cyc_i, stb_i, we_i, ack_o, wmk_level, irq;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int bad_count = 0;
  int compares = 0;
  row_t rows[5] = '{
    '{MODE_FIFO, 1'b1, 10'h2, 3, 32'h3, 1'b1},
    '{MODE_STREAM, 1'b0, 10'h5, 3, 32'h3, 1'b0},
    '{MODE_TRIG, 1'b1, 10'h2, 4, 32'h2, 1'b0},
    '{MODE_FILO, 1'b1, 10'h4, 4, 32'h4, 1'b1},
    '{MODE_TRIG, 1'b0, 10'h3, 2, 32'h2, 1'b0}};

  motion_sample_buffer i_motion_sample_buffer (.ref_clk(ref_clk),
    .rst_n(rst_n), .sample_valid(sample_valid), .sample_data(sample_data),
    .motion_irq(motion_irq), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .wmk_level(wmk_level), .irq(irq));
  host_reg_master i_host_reg_master (.ref_clk(ref_clk), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
    .wdat(dat_i), .rdat(dat_o), .ack_i(ack_o));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [47:0] samp(input int k);
    return {3{k[15:0]}} ^ 48'h3c5a_a53c_0ff0;
  endfunction
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_host_reg_master.access(1'b1, a, d, rd);
  endtask
  task automatic rdr(input logic [4:0] a);
    i_host_reg_master.access(1'b0, a, 32'h0, rd);
  endtask
  task automatic setup(input mode_t md, input logic res,
                       input logic [9:0] th);
    wr(OFS_CTRL, {29'h0, res, md});
    wr(OFS_THRESH, {22'h0, th});
  endtask
  // sample k pushed with the spacing the sample port demands
  task automatic push(input int k);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sample_data <= samp(k);
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic rdb(input int k, input int b);
    logic [47:0] s;
    s = samp(k);
    rdr(OFS_DATA);
    chk_reg({24'h0, rd[7:0]}, {24'h0, s[8*b +: 8]});
  endtask
  // low resolution: byte b is the high byte of axis b
  task automatic rdl(input int k, input int b);
    logic [47:0] s;
    s = samp(k);
    rdr(OFS_DATA);
    chk_reg({24'h0, rd[7:0]}, {24'h0, s[16*b+8 +: 8]});
  endtask
  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // generous: three full-buffer fills dominate the run
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    close_out;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample_data = 48'h0;
    motion_irq = 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(irq, 1'b0);
    chk_bit(ack_o, 1'b0);
    chk_bit(wmk_level, 1'b1);
    chk_reg(dat_o, 32'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'h0);
    rdr(OFS_MASK);
    chk_reg(rd, 32'h0);
    rdr(5'h1c);
    chk_reg(rd, 32'h0);
    foreach (rows[i]) begin
      setup(rows[i].md, rows[i].res, rows[i].th);
      for (int k = 1; k <= rows[i].n; k++) push(k);
      rdr(OFS_LEVEL);
      chk_reg(rd, rows[i].lvl);
      chk_bit(wmk_level, rows[i].wmk);
    end
    // byte order of the oldest sample, then newest-first in filo
    setup(MODE_FIFO, 1'b1, 10'h3);
    push(1);
    push(2);
    for (int b = 0; b < 6; b++) rdb(1, b);
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'h1);
    setup(MODE_FILO, 1'b1, 10'h3);
    for (int k = 1; k <= 3; k++) push(k);
    for (int b = 5; b >= 0; b--) rdb(3, b);
    rdb(2, 5);
    // low resolution keeps the high bytes, an empty buffer reads 0
    setup(MODE_FIFO, 1'b0, 10'h3);
    push(1);
    for (int b = 0; b < 3; b++) rdl(1, b);
    rdr(OFS_DATA);
    chk_reg(rd, 32'h0);
    // full buffer: fifo refuses, stream drops the oldest
    setup(MODE_FIFO, 1'b1, 10'h3);
    for (int k = 1; k <= int'(CAP_HI) + 1; k++) push(k);
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'(CAP_HI));
    rdr(OFS_STATUS);
    chk_bit(rd[ST_FULL], 1'b1);
    rdb(1, 0);
    setup(MODE_STREAM, 1'b1, 10'h3);
    for (int k = 1; k <= int'(CAP_HI) + 1; k++) push(k);
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'(CAP_HI));
    rdb(2, 0);
    // trigger capture keeps the threshold window before the event
    setup(MODE_TRIG, 1'b1, 10'h3);
    // an event before the window is complete must not trigger
    for (int k = 1; k <= 5; k++) begin
      push(k);
      if (k == 2 || k == 5) begin
        @(posedge ref_clk);
        motion_irq <= 1'b1;
        @(posedge ref_clk);
        motion_irq <= 1'b0;
        rdr(OFS_STATE);
        chk_bit(rd[ST_TRIG], k == 5);
      end
    end
    for (int k = 6; k <= int'(CAP_HI) + 5; k++) push(k);
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'(CAP_HI));
    rdb(3, 0);
    // watermark interrupt: masked, unmasked, held, cleared
    setup(MODE_FIFO, 1'b1, 10'h2);
    wr(OFS_MASK, 32'h0);
    push(1);
    push(2);
    @(negedge ref_clk);
    chk_bit(irq, 1'b0);
    wr(OFS_MASK, 32'h1);
    @(negedge ref_clk);
    chk_bit(irq, 1'b1);
    for (int b = 0; b < 5; b++) rdb(1, b);
    chk_bit(wmk_level, 1'b1);
    rdb(1, 5);
    @(negedge ref_clk);
    chk_bit(wmk_level, 1'b0);
    rdr(OFS_STATUS);
    chk_bit(rd[ST_WMK], 1'b1);
    @(negedge ref_clk);
    chk_bit(irq, 1'b0);
    // reset in mid-run empties the buffer and clears the mask
    push(1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(wmk_level, 1'b1);
    chk_bit(irq, 1'b0);
    chk_bit(ack_o, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rdr(OFS_LEVEL);
    chk_reg(rd, 32'h0);
    rdr(OFS_MASK);
    chk_reg(rd, 32'h0);
    close_out;
  end
endmodule
